//--- core/qsr_consts.svh
// constants for the questionable status reporting block
// Function
// - event words latch transitions until read
// - event read returns contents then clears
// - rising mask sets event on 0-1
// - falling mask sets event on 1-0
// - enabled true event raises group summary
// - summary rise feeds next level condition
// - questionable summary at status byte bit 3
// - limit summary at questionable bit 9
// - status bit 6 set in the same cycle as service request
// - condition word keeps showing live sources
// - operation bits 4, 5, 6 track acquisition
// - standard event read returns then clears
// - armed completion sets operation-complete flag
// - condition reads never alter condition word
// - operation summary at status byte bit 7
`ifndef QSR_CONSTS_SVH
`define QSR_CONSTS_SVH
`define QSR_WORD_W       16
`define QSR_QUES_LIMIT   9
`define QSR_OPER_MEAS    4
`define QSR_OPER_WTRIG   5
`define QSR_OPER_TRIGD   6
`define QSR_STB_QUES     3
`define QSR_STB_ESB      5
`define QSR_STB_RQS      6
`define QSR_STB_OPER     7
`define QSR_ESR_OPC      0
`define QSR_ZERO16       16'h0000
`define QSR_ZERO8        8'h00
`endif

//--- core/qsr_pkg.sv
// types for the questionable status reporting block
package qsr_pkg;
    typedef logic [15:0] qsr_word_t;
    typedef logic [7:0]  qsr_byte_t;
    typedef enum logic [0:0] {
        QSR_OPC_IDLE  = 1'b0,
        QSR_OPC_ARMED = 1'b1
    } qsr_opc_state_t;
endpackage : qsr_pkg

//--- core/qsr_status.sv
// status reporting tree: limit group, questionable, operation, status byte
`timescale 1ns/1ps
`default_nettype none
`include "qsr_consts.svh"

module qsr_status #(
    parameter int LIMIT_W = 8
) (
    // clock, reset, clock enable
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // live sources
    input  wire logic [LIMIT_W-1:0] limit_cond,
    input  wire qsr_pkg::qsr_word_t ques_cond_in,
    input  wire logic              acq_measuring,
    input  wire logic              acq_awaiting_trigger_flag,
    input  wire logic              acq_triggered,
    // limit group masks
    input  wire logic [LIMIT_W-1:0] limit_rising_filter_mask,
    input  wire logic [LIMIT_W-1:0] limit_falling_filter_mask,
    input  wire logic [LIMIT_W-1:0] limit_enable,
    // questionable masks
    input  wire qsr_pkg::qsr_word_t ques_rising_filter_mask,
    input  wire qsr_pkg::qsr_word_t ques_falling_filter_mask,
    input  wire qsr_pkg::qsr_word_t ques_enable,
    // operation masks
    input  wire qsr_pkg::qsr_word_t oper_rising_filter_mask,
    input  wire qsr_pkg::qsr_word_t oper_falling_filter_mask,
    input  wire qsr_pkg::qsr_word_t oper_enable,
    // service request enable, standard event enable
    input  wire qsr_pkg::qsr_byte_t srq_enable,
    input  wire qsr_pkg::qsr_byte_t esr_enable,
    // destructive reads, one-cycle strobes
    input  wire logic              limit_event_rd,
    input  wire logic              ques_event_rd,
    input  wire logic              oper_event_rd,
    input  wire logic              esr_rd,
    // completion handshake
    input  wire logic              opc_cmd,
    input  wire logic              ops_pending,
    // condition words
    output logic [LIMIT_W-1:0]     limit_cond_out,
    output qsr_pkg::qsr_word_t     ques_cond_out,
    output qsr_pkg::qsr_word_t     oper_cond_out,
    // event words
    output logic [LIMIT_W-1:0]     limit_event_out,
    output qsr_pkg::qsr_word_t     ques_event_out,
    output qsr_pkg::qsr_word_t     oper_event_out,
    output qsr_pkg::qsr_byte_t     esr_out,
    // status byte and service request
    output qsr_pkg::qsr_byte_t     status_byte,
    output logic                   srq_out
);
    import qsr_pkg::*;

    // widths the logic cannot serve are refused while elaborating
    if (LIMIT_W < 1 || LIMIT_W > `QSR_WORD_W) begin : g_bad_limit_w
        $error("LIMIT_W out of range");
    end
    // field positions must land inside the words they index
    if ($bits(qsr_word_t) != `QSR_WORD_W
            || `QSR_QUES_LIMIT >= `QSR_WORD_W
            || `QSR_OPER_TRIGD >= `QSR_WORD_W
            || `QSR_STB_OPER >= $bits(qsr_byte_t)) begin : g_bad_field
        $error("field position outside its word");
    end

    // transition filter for one bit: rising and falling edges, each masked
    function automatic logic qsr_qualify(
        input logic now_bit,
        input logic was_bit,
        input logic rise_en,
        input logic fall_en
    );
        qsr_qualify = (now_bit && !was_bit && rise_en)
                   || (!now_bit && was_bit && fall_en);
    endfunction : qsr_qualify

    // limit group
    logic [LIMIT_W-1:0] lim_cond_reg;
    logic [LIMIT_W-1:0] lim_evt_reg;
    logic [LIMIT_W-1:0] lim_evt_next;
    logic               lim_sum;
    logic [LIMIT_W-1:0] lim_qual;

    for (genvar gi = 0; gi < LIMIT_W; gi++) begin : g_lim_bit
        assign lim_qual[gi] = qsr_qualify(limit_cond[gi], lim_cond_reg[gi],
                                          limit_rising_filter_mask[gi],
                                          limit_falling_filter_mask[gi]);
    end
    // set wins over the read's clear
    assign lim_evt_next = (limit_event_rd ? '0 : lim_evt_reg)
                        | lim_qual;
    assign lim_sum = |(lim_evt_reg & limit_enable);

    // questionable group: limit summary feeds bit 9 of its condition
    // an outside bit 9 is dropped; the limit summary owns that place
    qsr_word_t ques_cond_now;
    qsr_word_t ques_cond_reg;
    qsr_word_t ques_evt_reg;
    qsr_word_t ques_evt_next;
    qsr_word_t ques_qual;
    logic      ques_sum;

    always_comb begin
        ques_cond_now = ques_cond_in;
        ques_cond_now[`QSR_QUES_LIMIT] = lim_sum;
    end
    for (genvar gq = 0; gq < `QSR_WORD_W; gq++) begin : g_ques_bit
        assign ques_qual[gq] = qsr_qualify(ques_cond_now[gq],
                                           ques_cond_reg[gq],
                                           ques_rising_filter_mask[gq],
                                           ques_falling_filter_mask[gq]);
    end
    assign ques_evt_next = (ques_event_rd ? '0 : ques_evt_reg) | ques_qual;
    assign ques_sum = |(ques_evt_reg & ques_enable);

    // operation group
    qsr_word_t oper_cond_now;
    qsr_word_t oper_cond_reg;
    qsr_word_t oper_evt_reg;
    qsr_word_t oper_evt_next;
    qsr_word_t oper_qual;
    logic      oper_sum;

    always_comb begin
        oper_cond_now = `QSR_ZERO16;
        oper_cond_now[`QSR_OPER_MEAS]  = acq_measuring;
        oper_cond_now[`QSR_OPER_WTRIG] = acq_awaiting_trigger_flag;
        oper_cond_now[`QSR_OPER_TRIGD] = acq_triggered;
    end
    for (genvar go = 0; go < `QSR_WORD_W; go++) begin : g_oper_bit
        assign oper_qual[go] = qsr_qualify(oper_cond_now[go],
                                           oper_cond_reg[go],
                                           oper_rising_filter_mask[go],
                                           oper_falling_filter_mask[go]);
    end
    assign oper_evt_next = (oper_event_rd ? '0 : oper_evt_reg) | oper_qual;
    assign oper_sum = |(oper_evt_reg & oper_enable);

    // standard event word and completion tracking
    qsr_byte_t      esr_reg;
    qsr_byte_t      esr_next;
    qsr_opc_state_t opc_state_reg;
    qsr_opc_state_t opc_state_next;
    logic           opc_done;

    // only the completion bit is used; the rest of the word stays zero
    assign opc_done = (opc_state_reg == QSR_OPC_ARMED)
                   && !ops_pending;
    always_comb begin
        esr_next = esr_rd ? `QSR_ZERO8 : esr_reg;
        if (opc_done) begin
            esr_next[`QSR_ESR_OPC] = 1'b1;
        end
    end
    // a second arm while armed is absorbed: one completion is tracked
    always_comb begin
        case (opc_state_reg)
            QSR_OPC_IDLE:  opc_state_next = opc_cmd ? QSR_OPC_ARMED
                                                    : QSR_OPC_IDLE;
            QSR_OPC_ARMED: opc_state_next = opc_done ? QSR_OPC_IDLE
                                                     : QSR_OPC_ARMED;
            default:       opc_state_next = QSR_OPC_IDLE;
        endcase
    end

    // status byte; request held until the status byte no longer asks
    qsr_byte_t stb_next;
    qsr_byte_t stb_full;
    logic      esb_sum;
    logic      rqs_next;

    assign esb_sum = |(esr_reg & esr_enable);
    always_comb begin
        stb_next = `QSR_ZERO8;
        stb_next[`QSR_STB_QUES] = ques_sum;
        stb_next[`QSR_STB_ESB]  = esb_sum;
        stb_next[`QSR_STB_OPER] = oper_sum;
    end
    // request is a level; it drops once the enabled events are read out
    assign rqs_next = |(stb_next & srq_enable);
    always_comb begin
        stb_full = stb_next;
        stb_full[`QSR_STB_RQS] = rqs_next;
    end

    // reset overrides clk_en so a frozen block can still be cleared
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lim_cond_reg    <= '0;
            lim_evt_reg     <= '0;
            ques_cond_reg   <= `QSR_ZERO16;
            ques_evt_reg    <= `QSR_ZERO16;
            oper_cond_reg   <= `QSR_ZERO16;
            oper_evt_reg    <= `QSR_ZERO16;
            esr_reg         <= `QSR_ZERO8;
            opc_state_reg   <= QSR_OPC_IDLE;
            status_byte     <= `QSR_ZERO8;
            srq_out         <= 1'b0;
        end else if (clk_en) begin
            lim_cond_reg    <= limit_cond;
            lim_evt_reg     <= lim_evt_next;
            ques_cond_reg   <= ques_cond_now;
            ques_evt_reg    <= ques_evt_next;
            oper_cond_reg   <= oper_cond_now;
            oper_evt_reg    <= oper_evt_next;
            esr_reg         <= esr_next;
            opc_state_reg   <= opc_state_next;
            status_byte     <= stb_full;
            srq_out         <= rqs_next;
        end
    end

    // condition outputs are plain registered copies; reads never touch them
    assign limit_cond_out  = lim_cond_reg;
    assign ques_cond_out   = ques_cond_reg;
    assign oper_cond_out   = oper_cond_reg;
    assign limit_event_out = lim_evt_reg;
    assign ques_event_out  = ques_evt_reg;
    assign oper_event_out  = oper_evt_reg;
    assign esr_out         = esr_reg;
endmodule : qsr_status
`default_nettype wire

//--- bench/qsr_status_chk.sv
// assertions on the status reporting tree ports
`timescale 1ns/1ps
`default_nettype none
module qsr_status_chk #(parameter int LIMIT_W = 8) (
    // clock and reset
    input wire logic               core_clk,
    input wire logic               sys_rst,
    input wire logic               clk_en,
    // limit group
    input wire logic [LIMIT_W-1:0] limit_cond,
    input wire logic [LIMIT_W-1:0] limit_rising_filter_mask,
    input wire logic [LIMIT_W-1:0] limit_falling_filter_mask,
    input wire logic               limit_event_rd,
    input wire logic [LIMIT_W-1:0] limit_cond_out,
    input wire logic [LIMIT_W-1:0] limit_event_out,
    // standard event and status byte
    input wire logic               esr_rd,
    input wire logic               ops_pending,
    input wire qsr_pkg::qsr_byte_t esr_out,
    input wire qsr_pkg::qsr_byte_t status_byte,
    input wire logic               srq_out
);
    import qsr_pkg::*;
    wire logic [LIMIT_W-1:0] rise_q;
    wire logic [LIMIT_W-1:0] fall_q;
    assign rise_q = limit_rising_filter_mask & limit_cond & ~limit_cond_out;
    assign fall_q = limit_falling_filter_mask & ~limit_cond & limit_cond_out;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_rise_latch: assert property (
        clk_en |=> (limit_event_out & $past(rise_q)) == $past(rise_q))
        else $error("rising event not latched");
    chk_fall_latch: assert property (
        clk_en |=> (limit_event_out & $past(fall_q)) == $past(fall_q))
        else $error("falling event not latched");
    chk_event_hold: assert property (
        clk_en && !limit_event_rd |=> (limit_event_out
            & $past(limit_event_out)) == $past(limit_event_out))
        else $error("event bit lost without read");
    chk_read_clears: assert property (
        clk_en && limit_event_rd |=>
            ~|(limit_event_out & ~$past(rise_q | fall_q)))
        else $error("event word not cleared by read");
    chk_cond_live: assert property (
        clk_en |=> limit_cond_out == $past(limit_cond))
        else $error("condition word not live");
    chk_request_bit: assert property (
        status_byte[6] == srq_out)
        else $error("request bit differs from request");
    chk_opc_wait: assert property (
        $rose(esr_out[0]) |-> !$past(ops_pending))
        else $error("completion flag while pending");
    chk_esr_clear: assert property (
        clk_en && esr_rd && ops_pending |=> esr_out == 8'h00)
        else $error("standard event word not cleared");
endmodule : qsr_status_chk
bind qsr_status qsr_status_chk #(.LIMIT_W(LIMIT_W)) u_chk (.core_clk,
    .sys_rst, .clk_en, .limit_cond, .limit_rising_filter_mask,
    .limit_falling_filter_mask, .limit_event_rd, .limit_cond_out,
    .limit_event_out, .esr_rd, .ops_pending, .esr_out, .status_byte,
    .srq_out);
`default_nettype wire

//--- bench/qsr_host.sv
// remote host model issuing status commands
`timescale 1ns/1ps
`default_nettype none
module qsr_host (
    // clock
    input  wire logic          core_clk,
    // commands to the block
    output qsr_pkg::qsr_byte_t srq_enable,
    output logic               opc_cmd
);
    import qsr_pkg::*;
    initial begin
        srq_enable = 8'h08;
        opc_cmd = 1'b0;
    end
    // one-cycle pulse, changed only at falling edges
    task automatic issue_opc;
        @(negedge core_clk) opc_cmd = 1'b1;
        @(negedge core_clk) opc_cmd = 1'b0;
    endtask : issue_opc
endmodule : qsr_host
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the status reporting tree
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) check(n, e, a)
module testbench;
    import qsr_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, opc_cmd, srq_out;
    logic [7:0] limit_cond = 8'h00, l_rise = 8'hff, l_fall = 8'h00;
    logic [7:0] l_en = 8'hff, l_cond_o, l_evt_o;
    logic meas = 1'b0, wtrig = 1'b0, trigd = 1'b0, ops_pending = 1'b0;
    logic l_rd = 1'b0, q_rd = 1'b0, o_rd = 1'b0, esr_rd = 1'b0;
    qsr_word_t q_m = 16'h0200, o_m = 16'hffff, zw = 16'h0000;
    qsr_word_t q_cond_o, q_evt_o, o_cond_o, o_evt_o;
    qsr_byte_t srq_enable, esr_o, stb;
    int fails = 0, tests_run = 0;
    qsr_host u_host (.core_clk, .srq_enable, .opc_cmd);
    qsr_status #(.LIMIT_W(8)) u_dut (.core_clk, .sys_rst, .clk_en,
        .limit_cond, .ques_cond_in(zw), .acq_measuring(meas),
        .acq_awaiting_trigger_flag(wtrig), .acq_triggered(trigd),
        .limit_rising_filter_mask(l_rise), .limit_enable(l_en),
        .limit_falling_filter_mask(l_fall), .ques_rising_filter_mask(q_m),
        .ques_falling_filter_mask(zw), .ques_enable(q_m),
        .oper_rising_filter_mask(o_m), .oper_falling_filter_mask(zw),
        .oper_enable(o_m), .srq_enable, .esr_enable(8'h00), .esr_rd,
        .limit_event_rd(l_rd), .ques_event_rd(q_rd), .oper_event_rd(o_rd),
        .opc_cmd, .ops_pending, .limit_cond_out(l_cond_o),
        .ques_cond_out(q_cond_o), .oper_cond_out(o_cond_o),
        .limit_event_out(l_evt_o), .ques_event_out(q_evt_o),
        .oper_event_out(o_evt_o), .esr_out(esr_o), .status_byte(stb),
        .srq_out);
    initial forever #5 core_clk = ~core_clk;
    task automatic tick(int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic check(string n, logic [15:0] e, logic [15:0] a);
        tests_run++;
        if (a !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, a);
        end
    endtask : check
    task automatic test_limit;
        limit_cond = 8'h03;
        tick(1);
        `CHK("limit_evt", 8'h03, l_evt_o);
        tick(1);
        `CHK("ques_evt", 16'h0200, q_evt_o);
        `CHK("ques_cond", 16'h0200, q_cond_o);
        tick(1);
        `CHK("stb", 8'h48, stb);
        `CHK("srq", 1'b1, srq_out);
        l_rd = 1'b1;
        limit_cond = 8'h07;
        `CHK("limit_rd", 8'h03, l_evt_o);
        tick(1);
        l_rd = 1'b0;
        `CHK("limit_new", 8'h04, l_evt_o);
        `CHK("limit_cond", 8'h07, l_cond_o);
        q_rd = 1'b1;
        `CHK("ques_rd", 16'h0200, q_evt_o);
        tick(1);
        q_rd = 1'b0;
        `CHK("cond_kept", 8'h07, l_cond_o);
        tick(2);
        `CHK("stb_clr", 8'h00, stb);
        l_fall = 8'hff;
        limit_cond = 8'h00;
        tick(1);
        `CHK("limit_fall", 8'h07, l_evt_o);
        $display("limit test done");
    endtask : test_limit
    task automatic test_oper;
        meas = 1'b1;
        tick(1);
        `CHK("oper_cond", 16'h0010, o_cond_o);
        wtrig = 1'b1;
        tick(1);
        `CHK("oper_cond", 16'h0030, o_cond_o);
        trigd = 1'b1;
        tick(2);
        `CHK("oper_cond", 16'h0070, o_cond_o);
        `CHK("stb_oper", 8'h80, stb);
        o_rd = 1'b1;
        `CHK("oper_rd", 16'h0070, o_evt_o);
        tick(1);
        o_rd = 1'b0;
        `CHK("oper_clr", 16'h0000, o_evt_o);
        meas = 1'b0;
        tick(1);
        `CHK("oper_cond", 16'h0060, o_cond_o);
        `CHK("stb_oper_clr", 8'h00, stb);
        $display("operation test done");
    endtask : test_oper
    task automatic test_opc;
        ops_pending = 1'b1;
        u_host.issue_opc();
        tick(2);
        `CHK("esr_wait", 8'h00, esr_o);
        ops_pending = 1'b0;
        tick(1);
        `CHK("esr_opc", 8'h01, esr_o);
        esr_rd = 1'b1;
        ops_pending = 1'b1;
        `CHK("esr_rd", 8'h01, esr_o);
        tick(1);
        esr_rd = 1'b0;
        `CHK("esr_clr", 8'h00, esr_o);
        $display("completion test done");
    endtask : test_opc
    task automatic test_freeze;
        clk_en = 1'b0;
        limit_cond = 8'h10;
        tick(2);
        `CHK("frz_cond", 8'h00, l_cond_o);
        `CHK("frz_evt", 8'h07, l_evt_o);
        clk_en = 1'b1;
        tick(1);
        `CHK("thaw_evt", 8'h17, l_evt_o);
        $display("freeze test done");
    endtask : test_freeze
    task automatic test_reset;
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        `CHK("rst_evt", 8'h00, l_evt_o);
        `CHK("rst_ques", 16'h0000, q_cond_o);
        tick(1);
        `CHK("rst_rise", 8'h10, l_evt_o);
        tick(2);
        `CHK("rst_ques_up", 16'h0200, q_evt_o);
        `CHK("rst_stb", 8'hc8, stb);
        $display("reset test done");
    endtask : test_reset
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        #20000;
        fails++;
        conclude();
    end
    initial begin
        tick(5);
        sys_rst = 1'b0;
        test_limit();
        test_oper();
        test_opc();
        test_freeze();
        test_reset();
        conclude();
    end
endmodule : testbench
`default_nettype wire
